// >>> wdd_pkg.sv
package wdd_pkg;

  // Opcode groups in the first halfword, bits 15:9
  localparam logic [6:0] PAIR_GROUP = 7'h74;
  localparam logic [6:0] DP_GROUP = 7'h75;

  // Field positions in the first halfword
  localparam int GRP_HI = 15;
  localparam int GRP_LO = 9;
  localparam int PAIR_SEL_BIT = 8;
  localparam int OFFSET_DIR_BIT = 7;
  localparam int PAIR_MID_BIT = 6;
  localparam int PAIR_IDX_BIT = 5;
  localparam int XFER_DIR_BIT = 4;
  localparam int OPC_HI = 8;
  localparam int OPC_LO = 5;
  localparam int FLAG_BIT = 4;
  localparam int BASE_HI = 3;
  localparam int BASE_LO = 0;

  // Field positions in the second halfword
  localparam int XFER1_HI = 15;
  localparam int XFER1_LO = 12;
  localparam int XFER2_HI = 11;
  localparam int XFER2_LO = 8;
  localparam int OFFS_HI = 7;
  localparam int OFFS_LO = 0;
  localparam int SH3_HI = 14;
  localparam int SH3_LO = 12;
  localparam int SH2_HI = 7;
  localparam int SH2_LO = 4;

  // Special field values
  localparam logic [3:0] REG_ALL_ONES = 4'hf;
  localparam logic [3:0] REG_STACK = 4'hd;
  localparam logic [6:0] SPEC_ROT_EXT = 7'h03;
  localparam logic [15:0] GATEWAY_HW2 = 16'he97f;

  // Opcode values of the shifted-register class
  localparam logic [3:0] OPC_CONJ = 4'h0;
  localparam logic [3:0] OPC_CLEAR = 4'h1;
  localparam logic [3:0] OPC_INCL_OR = 4'h2;
  localparam logic [3:0] OPC_OR_NOT = 4'h3;
  localparam logic [3:0] OPC_XOR = 4'h4;
  localparam logic [3:0] OPC_HOLE_A = 4'h5;
  localparam logic [3:0] OPC_PACK = 4'h6;
  localparam logic [3:0] OPC_HOLE_B = 4'h7;
  localparam logic [3:0] OPC_SUM = 4'h8;
  localparam logic [3:0] OPC_HOLE_C = 4'h9;
  localparam logic [3:0] OPC_SUM_CARRY = 4'ha;
  localparam logic [3:0] OPC_DIFF_BORROW = 4'hb;
  localparam logic [3:0] OPC_HOLE_D = 4'hc;
  localparam logic [3:0] OPC_DIFF = 4'hd;

  // Reset values of the output stage
  localparam logic [3:0] RST_REG = 4'h0;
  localparam logic [7:0] RST_OFFS = 8'h00;
  localparam logic [6:0] RST_SPEC = 7'h00;

  typedef enum logic [4:0] {
    OP_NONE,
    OP_PAIR_STORE,
    OP_PAIR_LOAD,
    OP_SECURE_ENTRY_GATEWAY,
    OP_BITWISE_CONJ,
    OP_BITWISE_CONJ_FLAGS,
    OP_CONJ_TEST,
    OP_BIT_CLEAR,
    OP_INCLUSIVE_OR,
    OP_INCLUSIVE_OR_FLAGS,
    OP_REG_COPY,
    OP_REG_COPY_FLAGS,
    OP_OR_NOT,
    OP_OR_NOT_FLAGS,
    OP_INVERTED_COPY,
    OP_INVERTED_COPY_FLAGS,
    OP_EXCLUSIVE_OR,
    OP_EXCLUSIVE_OR_FLAGS,
    OP_EQUIVALENCE_TEST,
    OP_PACK_BOTTOM_TOP,
    OP_PACK_TOP_BOTTOM,
    OP_SUM,
    OP_SUM_FLAGS,
    OP_NEGATIVE_COMPARE,
    OP_SUM_WITH_CARRY,
    OP_DIFFERENCE_WITH_BORROW,
    OP_DIFFERENCE
  } wdd_op_t;

endpackage

// >>> wdd_pair_decode.sv
`timescale 1ns/1ps

// Doubleword transfer and gateway decode, purely combinational
module wdd_pair_decode (
  input wire logic [15:0] hw1,
  input wire logic [15:0] hw2,
  output wdd_pkg::wdd_op_t pair_op,
  output logic pair_hit,
  output logic pair_undef,
  output logic pair_other,
  output logic pair_pre_index
);

  // Group selectors; the literal form is decoded elsewhere
  wire in_group = (hw1[wdd_pkg::GRP_HI:wdd_pkg::GRP_LO] == wdd_pkg::PAIR_GROUP)
    && hw1[wdd_pkg::PAIR_SEL_BIT] && hw1[wdd_pkg::PAIR_MID_BIT];
  wire pre_grp = in_group && hw1[wdd_pkg::PAIR_IDX_BIT];
  wire imm_grp = in_group && !hw1[wdd_pkg::PAIR_IDX_BIT];
  wire base_ones = hw1[wdd_pkg::BASE_HI:wdd_pkg::BASE_LO] == wdd_pkg::REG_ALL_ONES;
  wire load_dir = hw1[wdd_pkg::XFER_DIR_BIT];

  // Gateway needs offset_direction 0, xfer_direction 1 and the exact halfword
  wire gate_hit = pre_grp && base_ones && !hw1[wdd_pkg::OFFSET_DIR_BIT] && load_dir
    && (hw2 == wdd_pkg::GATEWAY_HW2);
  wire imm_hit = imm_grp && !base_ones;
  wire pre_hit = pre_grp && !base_ones;
  wire xfer_hit = imm_hit || pre_hit;

  // Other all-ones combinations in the pre-indexed group are unpredictable
  assign pair_undef = pre_grp && base_ones && !gate_hit;
  assign pair_other = imm_grp && base_ones; // Literal form, another decoder
  assign pair_hit = xfer_hit || gate_hit;
  assign pair_pre_index = pre_hit;
  assign pair_op = gate_hit ? wdd_pkg::OP_SECURE_ENTRY_GATEWAY :
    !xfer_hit ? wdd_pkg::OP_NONE :
    load_dir ? wdd_pkg::OP_PAIR_LOAD : wdd_pkg::OP_PAIR_STORE;

endmodule

// >>> wdd_decode.sv
`timescale 1ns/1ps

module wdd_decode (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic insn_valid,
  input wire logic [15:0] insn_hw1,
  input wire logic [15:0] insn_hw2,
  output logic dec_valid_q,
  output wdd_pkg::wdd_op_t dec_op_q,
  output logic dec_undef_q,
  output logic dec_other_q,
  output logic dec_rot_ext_q,
  output logic dec_stack_form_q,
  output logic dec_pre_index_q,
  output logic dec_offset_up_q,
  output logic [3:0] dec_base_q,
  output logic [3:0] dec_first_q,
  output logic [3:0] dec_second_q,
  output logic [7:0] dec_offset_q,
  output logic [6:0] dec_shift_q
);

  // Shifted-register op select; NONE means no operation from this class
  function automatic wdd_pkg::wdd_op_t dp_op(
    input logic [3:0] opc,
    input logic flg,
    input logic [3:0] src_reg,
    input logic [3:0] dst_reg,
    input logic [6:0] spec
  );
    logic src_ones;
    logic dst_ones;
    // All-ones register fields pick the copy, test and compare rows
    src_ones = (src_reg == wdd_pkg::REG_ALL_ONES);
    dst_ones = (dst_reg == wdd_pkg::REG_ALL_ONES);
    dp_op = wdd_pkg::OP_NONE;
    // Unlisted fields of each row are simply not looked at
    unique case (opc)
      wdd_pkg::OPC_CONJ: begin
        if (!flg) begin
          dp_op = wdd_pkg::OP_BITWISE_CONJ;
        end else begin
          dp_op = dst_ones ? wdd_pkg::OP_CONJ_TEST : wdd_pkg::OP_BITWISE_CONJ_FLAGS;
        end
      end
      wdd_pkg::OPC_CLEAR: begin
        dp_op = wdd_pkg::OP_BIT_CLEAR;
      end
      wdd_pkg::OPC_INCL_OR: begin
        if (src_ones) begin
          dp_op = flg ? wdd_pkg::OP_REG_COPY_FLAGS : wdd_pkg::OP_REG_COPY;
        end else begin
          dp_op = flg ? wdd_pkg::OP_INCLUSIVE_OR_FLAGS : wdd_pkg::OP_INCLUSIVE_OR;
        end
      end
      wdd_pkg::OPC_OR_NOT: begin
        if (src_ones) begin
          dp_op = flg ? wdd_pkg::OP_INVERTED_COPY_FLAGS : wdd_pkg::OP_INVERTED_COPY;
        end else begin
          dp_op = flg ? wdd_pkg::OP_OR_NOT_FLAGS : wdd_pkg::OP_OR_NOT;
        end
      end
      wdd_pkg::OPC_XOR: begin
        if (!flg) begin
          dp_op = wdd_pkg::OP_EXCLUSIVE_OR;
        end else begin
          dp_op = dst_ones ? wdd_pkg::OP_EQUIVALENCE_TEST :
            wdd_pkg::OP_EXCLUSIVE_OR_FLAGS;
        end
      end
      wdd_pkg::OPC_PACK: begin
        // Only the flag-clear even encodings are allocated
        if (!flg && !spec[0]) begin
          dp_op = spec[1] ? wdd_pkg::OP_PACK_TOP_BOTTOM : wdd_pkg::OP_PACK_BOTTOM_TOP;
        end
      end
      wdd_pkg::OPC_SUM: begin
        if (!flg) begin
          dp_op = wdd_pkg::OP_SUM;
        end else begin
          dp_op = dst_ones ? wdd_pkg::OP_NEGATIVE_COMPARE : wdd_pkg::OP_SUM_FLAGS;
        end
      end
      wdd_pkg::OPC_SUM_CARRY: begin
        dp_op = wdd_pkg::OP_SUM_WITH_CARRY;
      end
      wdd_pkg::OPC_DIFF_BORROW: begin
        dp_op = wdd_pkg::OP_DIFFERENCE_WITH_BORROW;
      end
      wdd_pkg::OPC_DIFF: begin
        if (!flg && src_reg != wdd_pkg::REG_STACK) begin
          dp_op = wdd_pkg::OP_DIFFERENCE;
        end
      end
      default: begin
        dp_op = wdd_pkg::OP_NONE;
      end
    endcase
  endfunction

  // Field extraction
  wire [3:0] opc = insn_hw1[wdd_pkg::OPC_HI:wdd_pkg::OPC_LO];
  wire flg = insn_hw1[wdd_pkg::FLAG_BIT];
  wire [3:0] base = insn_hw1[wdd_pkg::BASE_HI:wdd_pkg::BASE_LO];
  wire [3:0] xfer1 = insn_hw2[wdd_pkg::XFER1_HI:wdd_pkg::XFER1_LO];
  wire [3:0] xfer2 = insn_hw2[wdd_pkg::XFER2_HI:wdd_pkg::XFER2_LO];
  wire [7:0] offs = insn_hw2[wdd_pkg::OFFS_HI:wdd_pkg::OFFS_LO];
  wire [6:0] spec = {insn_hw2[wdd_pkg::SH3_HI:wdd_pkg::SH3_LO],
    insn_hw2[wdd_pkg::SH2_HI:wdd_pkg::SH2_LO]};

  // Shifted-register class selection
  wire dp_grp = insn_hw1[wdd_pkg::GRP_HI:wdd_pkg::GRP_LO] == wdd_pkg::DP_GROUP;
  wdd_pkg::wdd_op_t dp_sel;
  assign dp_sel = dp_op(opc, flg, base, xfer2, spec);
  // Holes are whole opcodes plus the odd or flag-set pack rows
  wire dp_hole = (opc == wdd_pkg::OPC_HOLE_A) || (opc == wdd_pkg::OPC_HOLE_B)
    || (opc == wdd_pkg::OPC_HOLE_C) || (opc == wdd_pkg::OPC_HOLE_D)
    || (opc == wdd_pkg::OPC_PACK && (flg || spec[0]));
  wire dp_undef = dp_grp && dp_hole;
  // A hit is any row that names an operation
  wire dp_hit = dp_grp && (dp_sel != wdd_pkg::OP_NONE);
  // Opcodes 1110, 1111 and the other 1101 rows belong to neighbouring logic
  wire dp_other = dp_grp && !dp_hole && !dp_hit;
  // Stack form only marks the sum rows; subtract rows never set it
  wire dp_stack = (opc == wdd_pkg::OPC_SUM) && (base == wdd_pkg::REG_STACK)
    && (dp_sel == wdd_pkg::OP_SUM || dp_sel == wdd_pkg::OP_SUM_FLAGS);
  // Marker only; execute ignores it for ops that take no shift
  wire dp_rot_ext = spec == wdd_pkg::SPEC_ROT_EXT;

  // Doubleword and gateway slice
  wdd_pkg::wdd_op_t pair_op;
  logic pair_hit;
  logic pair_undef;
  logic pair_other;
  logic pair_pre_index;

  // Slice flags are already exclusive, so no extra gating here
  wdd_pair_decode u_pair (
    .hw1(insn_hw1),
    .hw2(insn_hw2),
    .pair_op(pair_op),
    .pair_hit(pair_hit),
    .pair_undef(pair_undef),
    .pair_other(pair_other),
    .pair_pre_index(pair_pre_index)
  );

  // Merge; groups are disjoint so no priority is needed
  wdd_pkg::wdd_op_t op_d;
  assign op_d = pair_hit ? pair_op : (dp_hit ? dp_sel : wdd_pkg::OP_NONE);
  wire undef_d = insn_valid && (pair_undef || dp_undef);
  // Unclaimed encodings go to neighbouring decoders, not to the trap
  wire other_d = insn_valid && (pair_other || dp_other || !(pair_hit || dp_hit
    || pair_undef || dp_undef));
  // Undefined encodings never issue an operation
  wire issue_d = insn_valid && (pair_hit || dp_hit);
  // Shifted-register ops carry the destination in the first slot
  wire [3:0] first_d = dp_hit ? xfer2 : xfer1;
  wire [3:0] second_d = dp_hit ? wdd_pkg::RST_REG : xfer2;
  // Unused fields read zero so stale bits never reach execute
  wire [7:0] offs_d = pair_hit ? offs : wdd_pkg::RST_OFFS;
  wire [6:0] spec_d = dp_hit ? spec : wdd_pkg::RST_SPEC;

  // Control outputs; one cycle of latency keeps outputs off raw logic
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dec_valid_q <= 1'b0;
      dec_op_q <= wdd_pkg::OP_NONE;
      dec_undef_q <= 1'b0;
      dec_other_q <= 1'b0;
      dec_rot_ext_q <= 1'b0;
      dec_stack_form_q <= 1'b0;
      dec_pre_index_q <= 1'b0;
      dec_offset_up_q <= 1'b0;
    end else begin
      dec_valid_q <= issue_d;
      dec_op_q <= issue_d ? op_d : wdd_pkg::OP_NONE;
      dec_undef_q <= undef_d;
      dec_other_q <= other_d;
      dec_rot_ext_q <= issue_d && dp_hit && dp_rot_ext;
      dec_stack_form_q <= issue_d && dp_hit && dp_stack;
      dec_pre_index_q <= issue_d && pair_pre_index;
      dec_offset_up_q <= issue_d && pair_hit && insn_hw1[wdd_pkg::OFFSET_DIR_BIT];
    end
  end

  // Operand fields ride along with the op
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dec_base_q <= wdd_pkg::RST_REG;
      dec_first_q <= wdd_pkg::RST_REG;
      dec_second_q <= wdd_pkg::RST_REG;
      dec_offset_q <= wdd_pkg::RST_OFFS;
      dec_shift_q <= wdd_pkg::RST_SPEC;
    end else begin
      dec_base_q <= base;
      dec_first_q <= first_d;
      dec_second_q <= second_d;
      dec_offset_q <= offs_d;
      dec_shift_q <= spec_d;
    end
  end

endmodule

// >>> wdd_decode_sva.sv
`timescale 1ns/1ps

module wdd_decode_sva (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic insn_valid,
  input wire logic [15:0] insn_hw1,
  input wire logic [15:0] insn_hw2,
  input wire logic dec_valid_q,
  input wire wdd_pkg::wdd_op_t dec_op_q,
  input wire logic dec_undef_q,
  input wire logic dec_other_q,
  input wire logic dec_rot_ext_q,
  input wire logic dec_pre_index_q,
  input wire logic [3:0] dec_first_q,
  input wire logic [7:0] dec_offset_q
);
  logic live_q;
  // Past values count only once an edge out of reset has passed
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) live_q <= 1'b0;
    else live_q <= 1'b1;
  end
  // Decode conditions of the taking cycle
  wire logic pair_w = insn_valid && insn_hw1[15:9] == wdd_pkg::PAIR_GROUP && insn_hw1[8];
  wire logic base_f_w = insn_hw1[3:0] == 4'hf;
  wire logic imm_w = pair_w && insn_hw1[6:5] == 2'b10 && !base_f_w;
  wire logic pre_w = pair_w && insn_hw1[6:5] == 2'b11 && !base_f_w;
  wire logic gsel_w = pair_w && insn_hw1[6:5] == 2'b11 && base_f_w;
  wire logic gate_w = insn_hw1 == 16'he97f && insn_hw2 == wdd_pkg::GATEWAY_HW2;
  wire logic dp_w = insn_valid && insn_hw1[15:9] == wdd_pkg::DP_GROUP;
  wire logic [3:0] opc_w = insn_hw1[8:5];
  wire logic flg_w = insn_hw1[4];
  wire logic rot_w = {insn_hw2[14:12], insn_hw2[7:4]} == wdd_pkg::SPEC_ROT_EXT;
  wire logic clr_w = dp_w && opc_w == wdd_pkg::OPC_CLEAR;
  wire logic conj_w = dp_w && opc_w == wdd_pkg::OPC_CONJ && flg_w;
  wire logic hole_w = dp_w && opc_w inside {4'h5, 4'h7, 4'h9, 4'hc};

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_one;
    live_q && $past(insn_valid) |-> $onehot({dec_valid_q, dec_undef_q, dec_other_q});
  endproperty
  a_one: assert property (p_one) else $error("not one flag per instruction");
  property p_idle;
    live_q && !$past(insn_valid) |-> !dec_valid_q && !dec_undef_q && !dec_other_q;
  endproperty
  a_idle: assert property (p_idle) else $error("flag without instruction");
  property p_imm;
    live_q && $past(imm_w) |-> dec_valid_q && !dec_pre_index_q &&
      dec_op_q == ($past(flg_w) ? wdd_pkg::OP_PAIR_LOAD : wdd_pkg::OP_PAIR_STORE);
  endproperty
  a_imm: assert property (p_imm) else $error("immediate pair wrong");
  property p_pre;
    live_q && $past(pre_w) |-> dec_pre_index_q && dec_first_q == $past(insn_hw2[15:12]) &&
      dec_offset_q == $past(insn_hw2[7:0]);
  endproperty
  a_pre: assert property (p_pre) else $error("pre-indexed pair wrong");
  property p_gate;
    live_q && $past(gsel_w) |->
      ($past(gate_w) ? dec_op_q == wdd_pkg::OP_SECURE_ENTRY_GATEWAY : dec_undef_q);
  endproperty
  a_gate: assert property (p_gate) else $error("gateway group wrong");
  property p_clr;
    live_q && $past(clr_w) |-> dec_valid_q && dec_op_q == wdd_pkg::OP_BIT_CLEAR;
  endproperty
  a_clr: assert property (p_clr) else $error("bit clear wrong");
  property p_rot;
    live_q && $past(conj_w) |-> dec_rot_ext_q == $past(rot_w);
  endproperty
  a_rot: assert property (p_rot) else $error("rotate extend wrong");
  property p_hole;
    live_q && $past(hole_w) |-> dec_undef_q && dec_op_q == wdd_pkg::OP_NONE;
  endproperty
  a_hole: assert property (p_hole) else $error("hole opcode issued");

  c_gate: cover property (dec_op_q == wdd_pkg::OP_SECURE_ENTRY_GATEWAY);
  c_undef: cover property (dec_undef_q);
  c_rot: cover property (dec_rot_ext_q && dec_valid_q);
endmodule

bind wdd_decode wdd_decode_sva u_sva (.clk_sys, .reset_n, .insn_valid, .insn_hw1, .insn_hw2,
  .dec_valid_q, .dec_op_q, .dec_undef_q, .dec_other_q, .dec_rot_ext_q, .dec_pre_index_q,
  .dec_first_q, .dec_offset_q);

// >>> wdd_fetch_model.sv
`timescale 1ns/1ps

module wdd_fetch_model (
  input wire logic clk_sys,
  output logic insn_valid,
  output logic [15:0] insn_hw1,
  output logic [15:0] insn_hw2
);
  initial begin
    insn_valid = 1'b0;
    {insn_hw1, insn_hw2} = 32'h0000_0000;
  end
  // Both halfwords launch together on the falling edge, away from the sampling edge
  task automatic send(input logic [31:0] w);
    @(negedge clk_sys);
    insn_valid = 1'b1;
    {insn_hw1, insn_hw2} = w;
  endtask
  // Idle words invert so a stale instruction never looks held
  task automatic idle();
    @(negedge clk_sys);
    insn_valid = 1'b0;
    {insn_hw1, insn_hw2} = ~{insn_hw1, insn_hw2};
  endtask
endmodule

// >>> tb_wdd_decode.sv
`timescale 1ns/1ps

module tb_wdd_decode;
  typedef struct packed {
    logic [31:0] w;
    wdd_pkg::wdd_op_t op;
    logic [2:0] f;
  } wdd_row_t;
  localparam logic [2:0] FV = 3'b100;
  localparam logic [2:0] FU = 3'b010;
  localparam logic [2:0] FO = 3'b001;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic insn_valid;
  logic [15:0] insn_hw1, insn_hw2;
  logic dec_valid_q, dec_undef_q, dec_other_q, dec_rot_ext_q, dec_stack_form_q;
  logic dec_pre_index_q, dec_offset_up_q;
  wdd_pkg::wdd_op_t dec_op_q;
  logic [3:0] dec_base_q, dec_first_q, dec_second_q;
  logic [7:0] dec_offset_q;
  logic [6:0] dec_shift_q;
  int failures = 0;
  int compares = 0;
  // Instruction word, expected operation, expected valid/undef/other
  wdd_row_t rows [$] = '{
    '{32'hE9C5_1234, wdd_pkg::OP_PAIR_STORE, FV},
    '{32'hE9D5_1234, wdd_pkg::OP_PAIR_LOAD, FV},
    '{32'hE9DF_1234, wdd_pkg::OP_NONE, FO},
    '{32'hE9E5_1234, wdd_pkg::OP_PAIR_STORE, FV},
    '{32'hE97F_E97F, wdd_pkg::OP_SECURE_ENTRY_GATEWAY, FV},
    '{32'hE97F_E97E, wdd_pkg::OP_NONE, FU},
    '{32'hE9FF_E97F, wdd_pkg::OP_NONE, FU},
    '{32'hEA03_0F30, wdd_pkg::OP_BITWISE_CONJ, FV},
    '{32'hEA13_0200, wdd_pkg::OP_BITWISE_CONJ_FLAGS, FV},
    '{32'hEA13_0F30, wdd_pkg::OP_CONJ_TEST, FV},
    '{32'hEA3F_0F00, wdd_pkg::OP_BIT_CLEAR, FV},
    '{32'hEA41_0200, wdd_pkg::OP_INCLUSIVE_OR, FV},
    '{32'hEA4F_0200, wdd_pkg::OP_REG_COPY, FV},
    '{32'hEA51_0200, wdd_pkg::OP_INCLUSIVE_OR_FLAGS, FV},
    '{32'hEA5F_0200, wdd_pkg::OP_REG_COPY_FLAGS, FV},
    '{32'hEA61_0200, wdd_pkg::OP_OR_NOT, FV},
    '{32'hEA6F_0200, wdd_pkg::OP_INVERTED_COPY, FV},
    '{32'hEA71_0200, wdd_pkg::OP_OR_NOT_FLAGS, FV},
    '{32'hEA7F_0200, wdd_pkg::OP_INVERTED_COPY_FLAGS, FV},
    '{32'hEA81_0F00, wdd_pkg::OP_EXCLUSIVE_OR, FV},
    '{32'hEA91_0200, wdd_pkg::OP_EXCLUSIVE_OR_FLAGS, FV},
    '{32'hEA91_0F30, wdd_pkg::OP_EQUIVALENCE_TEST, FV},
    '{32'hEAC1_0200, wdd_pkg::OP_PACK_BOTTOM_TOP, FV},
    '{32'hEAC1_0220, wdd_pkg::OP_PACK_TOP_BOTTOM, FV},
    '{32'hEAC1_0210, wdd_pkg::OP_NONE, FU},
    '{32'hEAD1_0200, wdd_pkg::OP_NONE, FU},
    '{32'hEB01_0200, wdd_pkg::OP_SUM, FV},
    '{32'hEB11_0200, wdd_pkg::OP_SUM_FLAGS, FV},
    '{32'hEB11_0F00, wdd_pkg::OP_NEGATIVE_COMPARE, FV},
    '{32'hEB41_0200, wdd_pkg::OP_SUM_WITH_CARRY, FV},
    '{32'hEB61_0200, wdd_pkg::OP_DIFFERENCE_WITH_BORROW, FV},
    '{32'hEAA1_0200, wdd_pkg::OP_NONE, FU},
    '{32'hEAE1_0200, wdd_pkg::OP_NONE, FU},
    '{32'hEB21_0200, wdd_pkg::OP_NONE, FU},
    '{32'hEB81_0200, wdd_pkg::OP_NONE, FU},
    '{32'hEBA1_0200, wdd_pkg::OP_DIFFERENCE, FV},
    '{32'hEBAD_0200, wdd_pkg::OP_NONE, FO},
    '{32'hEBB1_0200, wdd_pkg::OP_NONE, FO},
    '{32'hEBC1_0200, wdd_pkg::OP_NONE, FO},
    '{32'hEBF1_0200, wdd_pkg::OP_NONE, FO},
    '{32'hEAC1_0230, wdd_pkg::OP_NONE, FU},
    '{32'hE8E5_1234, wdd_pkg::OP_NONE, FO},
    '{32'hF000_8000, wdd_pkg::OP_NONE, FO}
  };

  wdd_decode uut (.clk_sys, .reset_n, .insn_valid, .insn_hw1, .insn_hw2, .dec_valid_q,
    .dec_op_q, .dec_undef_q, .dec_other_q, .dec_rot_ext_q, .dec_stack_form_q, .dec_pre_index_q,
    .dec_offset_up_q, .dec_base_q, .dec_first_q, .dec_second_q, .dec_offset_q, .dec_shift_q);
  wdd_fetch_model model (.clk_sys, .insn_valid, .insn_hw1, .insn_hw2);

  always #50 clk_sys = ~clk_sys;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares = compares + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Result is looked at just after the edge that registers it
  task automatic issue(input logic [31:0] w);
    model.send(w);
    @(posedge clk_sys);
    #1;
  endtask
  task automatic end_of_test();
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Back to back rows, then fields, idle and a reset in mid-run
  initial begin
    repeat (5) @(posedge clk_sys);
    #1;
    chk("reset", 32'h0000_0000, {dec_valid_q, dec_op_q, dec_first_q, dec_offset_q});
    @(negedge clk_sys);
    reset_n = 1'b1;
    foreach (rows[i]) begin
      issue(rows[i].w);
      chk("op", rows[i].op, dec_op_q);
      chk("flags", rows[i].f, {dec_valid_q, dec_undef_q, dec_other_q});
    end
    issue(32'hE9E5_1234);
    chk("pair", {1'b1, 1'b1, 4'h5}, {dec_pre_index_q, dec_offset_up_q, dec_base_q});
    chk("pair regs", {4'h1, 4'h2, 8'h34}, {dec_first_q, dec_second_q, dec_offset_q});
    issue(32'hEB0D_0200);
    chk("stack", {wdd_pkg::OP_SUM, 1'b1}, {dec_op_q, dec_stack_form_q});
    issue(32'hEB1D_0200);
    chk("stack flags", {wdd_pkg::OP_SUM_FLAGS, 1'b1}, {dec_op_q, dec_stack_form_q});
    issue(32'hEA13_0F30);
    chk("rot", {1'b1, 4'hf, 7'h03}, {dec_rot_ext_q, dec_first_q, dec_shift_q});
    issue(32'hEA93_0F10);
    chk("no rot", {wdd_pkg::OP_EQUIVALENCE_TEST, 1'b0}, {dec_op_q, dec_rot_ext_q});
    model.idle();
    @(posedge clk_sys);
    #1;
    chk("idle", {wdd_pkg::OP_NONE, 3'b000}, {dec_op_q, dec_valid_q, dec_undef_q, dec_other_q});
    issue(32'hE97F_E97F);
    chk("gate", {wdd_pkg::OP_SECURE_ENTRY_GATEWAY, 1'b0}, {dec_op_q, dec_pre_index_q});
    @(negedge clk_sys);
    reset_n = 1'b0;
    #1;
    chk("mid reset", 32'h0000_0000, {dec_valid_q, dec_op_q});
    @(negedge clk_sys);
    reset_n = 1'b1;
    issue(32'hEBA1_0200);
    chk("after reset", wdd_pkg::OP_DIFFERENCE, dec_op_q);
    end_of_test();
  end

  // Watchdog well past the fifty-nine or so cycles the sequence needs
  initial begin
    #100_000;
    failures = failures + 1;
    end_of_test();
  end
endmodule
